// *** design/nas_annunciator.sv ***
// navigation annunciator lamps, panel toggles and simulation strap
//
// Functional notes
// - new unacknowledged message flashes status lamp
// - effective messages with none new: steady
// - within 10 s of turn point: flash
// - turn lamp steady through the turn
// - arrival alarm radius entry flashes 10 s
// - no alarm: flash near arrival waypoint
// - source toggle low pulse flips nav source
// - radio lamp: single indicator showing radio
// - satellite lamp: single indicator showing satellite
// - course-hold low pulse flips hold mode
// - leg lamp when no hold/suspend shown
// - hold lamp when hold or suspend shown
// - approach, within 30 nm, scale small
// - approach active lights final segment lamp
// - position error or no integrity: lamp
// - precision gain for gps or ils approach
// - low strap at power-up selects simulation
`timescale 1ns/1ps
module nas_annunciator #(
  parameter logic [31:0] ARRIVAL_CYC = nas_pkg::ARRIVAL_FLASH_CYC[31:0],
  parameter logic [31:0] DEBOUNCE_CYC = nas_pkg::DEBOUNCE_CYC[31:0]
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic nav_source_toggle_input_n,
  input wire logic course_hold_toggle_input_n,
  input wire logic sim_select_n,
  output logic status_note_lamp,
  output logic turn_point_lamp,
  output logic radio_nav_lamp,
  output logic satellite_nav_lamp,
  output logic leg_sequencing_lamp,
  output logic course_hold_lamp,
  output logic near_airport_lamp,
  output logic final_segment_lamp,
  output logic position_trust_lamp,
  output logic precision_gain_output
);
  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  nas_pkg::nas_nav_state_s state_reg;
  nas_pkg::nas_lamps_s lamps_next;
  nas_pkg::nas_lamps_s lamps_reg;
  logic [31:0] flash_half_reg;
  logic src_gps_reg;
  logic course_hold_mode_reg;
  logic sim_mode_reg;
  logic strap_taken_reg;
  logic radius_prev_reg;
  logic [31:0] arrival_cnt_reg;
  logic flash_on;
  logic src_fall;
  logic hold_fall;
  logic src_key;
  logic hold_key;
  logic alarm_entry;
  logic hold_shown;

  // -------------------------------------------------------------------------
  // discrete inputs
  // -------------------------------------------------------------------------
  nas_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_src_db (
    .clk(clk),
    .srst(srst),
    .pin_n(nav_source_toggle_input_n),
    .fall_pulse(src_fall)
  );

  nas_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_hold_db (
    .clk(clk),
    .srst(srst),
    .pin_n(course_hold_toggle_input_n),
    .fall_pulse(hold_fall)
  );

  nas_flash u_flash (
    .clk(clk),
    .srst(srst),
    .half_period(flash_half_reg),
    .flash_on(flash_on)
  );

  // -------------------------------------------------------------------------
  // register writes
  // -------------------------------------------------------------------------
  // write strobe aimed at one register offset
  function automatic logic wr_hit(input logic we, input logic [7:0] a, input logic [7:0] off);
    return we && (a == off);
  endfunction

  assign src_key = wr_hit(wr_en, addr, nas_pkg::OFF_KEY) && wdata[nas_pkg::KEY_SRC_BIT];
  assign hold_key = wr_hit(wr_en, addr, nas_pkg::OFF_KEY) && wdata[nas_pkg::KEY_HOLD_BIT];

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= nas_pkg::NAV_STATE_RST;
    end else if (wr_hit(wr_en, addr, nas_pkg::OFF_NAV_STATE)) begin
      state_reg <= wdata[16:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      flash_half_reg <= nas_pkg::FLASH_HALF_RST;
    end else if (wr_hit(wr_en, addr, nas_pkg::OFF_FLASH_HALF)) begin
      flash_half_reg <= wdata;
    end
  end

  // -------------------------------------------------------------------------
  // panel key equivalents
  // -------------------------------------------------------------------------
  // pin and software key in one cycle count as a single press
  always_ff @(posedge clk) begin
    if (srst) begin
      src_gps_reg <= nas_pkg::SRC_GPS_RST;
    end else if (src_fall || src_key) begin
      src_gps_reg <= !src_gps_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      course_hold_mode_reg <= 1'b0;
    end else if (hold_fall || hold_key) begin
      course_hold_mode_reg <= !course_hold_mode_reg;
    end
  end

  // -------------------------------------------------------------------------
  // simulation strap
  // -------------------------------------------------------------------------
  // caught once, in the first cycle after reset release; later changes ignored
  always_ff @(posedge clk) begin
    if (srst) begin
      strap_taken_reg <= 1'b0;
      sim_mode_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      sim_mode_reg <= !sim_select_n;
    end
  end

  // -------------------------------------------------------------------------
  // arrival alarm window
  // -------------------------------------------------------------------------
  assign alarm_entry = state_reg.alarm_set && state_reg.in_alarm_radius && !radius_prev_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      radius_prev_reg <= 1'b0;
    end else begin
      radius_prev_reg <= state_reg.in_alarm_radius;
    end
  end

  // fresh entry restarts the window even if the last one is still running
  always_ff @(posedge clk) begin
    if (srst) begin
      arrival_cnt_reg <= 32'h0;
    end else if (alarm_entry) begin
      arrival_cnt_reg <= ARRIVAL_CYC;
    end else if (arrival_cnt_reg != 32'h0) begin
      arrival_cnt_reg <= arrival_cnt_reg - 32'h1;
    end
  end

  // -------------------------------------------------------------------------
  // lamp decode
  // -------------------------------------------------------------------------
  assign hold_shown = course_hold_mode_reg || state_reg.leg_suspend;

  always_comb begin
    lamps_next = '0;
    if (state_reg.new_msg) begin
      lamps_next.status_note_lamp = flash_on;
    end else begin
      lamps_next.status_note_lamp = state_reg.msgs_active;
    end
    if (state_reg.in_turn) begin
      lamps_next.turn_point_lamp = 1'b1;
    end else if (state_reg.near_turn || arrival_cnt_reg != 32'h0 ||
                 (!state_reg.alarm_set && state_reg.near_arrival)) begin
      lamps_next.turn_point_lamp = flash_on;
    end
    lamps_next.radio_nav_lamp = state_reg.single_indicator && !src_gps_reg;
    lamps_next.satellite_nav_lamp = state_reg.single_indicator && src_gps_reg;
    lamps_next.leg_sequencing_lamp = !hold_shown;
    lamps_next.course_hold_lamp = hold_shown;
    lamps_next.near_airport_lamp = state_reg.approach_nav && state_reg.within_30nm &&
                                   state_reg.scale_le_1nm;
    lamps_next.final_segment_lamp = state_reg.approach_nav && state_reg.appr_active;
    lamps_next.position_trust_lamp = state_reg.pos_error || state_reg.integ_unavail;
    lamps_next.precision_gain_output = (src_gps_reg && state_reg.gps_appr_active) ||
                                       (!src_gps_reg && state_reg.ils_tuned);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lamps_reg <= '0;
    end else begin
      lamps_reg <= lamps_next;
    end
  end

  assign status_note_lamp = lamps_reg.status_note_lamp;
  assign turn_point_lamp = lamps_reg.turn_point_lamp;
  assign radio_nav_lamp = lamps_reg.radio_nav_lamp;
  assign satellite_nav_lamp = lamps_reg.satellite_nav_lamp;
  assign leg_sequencing_lamp = lamps_reg.leg_sequencing_lamp;
  assign course_hold_lamp = lamps_reg.course_hold_lamp;
  assign near_airport_lamp = lamps_reg.near_airport_lamp;
  assign final_segment_lamp = lamps_reg.final_segment_lamp;
  assign position_trust_lamp = lamps_reg.position_trust_lamp;
  assign precision_gain_output = lamps_reg.precision_gain_output;

  // -------------------------------------------------------------------------
  // register reads
  // -------------------------------------------------------------------------
  // key register is write-only; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 32'h0;
    end else if (rd_en) begin
      unique case (addr)
        nas_pkg::OFF_NAV_STATE: rdata <= {15'h0, state_reg};
        nas_pkg::OFF_FLASH_HALF: rdata <= flash_half_reg;
        nas_pkg::OFF_STATUS: rdata <= {14'h0, lamps_reg, 5'h0, sim_mode_reg, course_hold_mode_reg, src_gps_reg};
        default: rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence alarm_entry_seq;
    !state_reg.in_alarm_radius ##1 (state_reg.alarm_set && state_reg.in_alarm_radius);
  endsequence

  sequence arrival_flash_seq;
    (arrival_cnt_reg == ARRIVAL_CYC) ##1 (arrival_cnt_reg == ARRIVAL_CYC - 32'h1);
  endsequence

  status_flash_a: assert property (state_reg.new_msg |=> status_note_lamp == $past(flash_on))
    else $error("status lamp not flashing for new message");

  status_steady_a: assert property (!state_reg.new_msg && state_reg.msgs_active |=> status_note_lamp)
    else $error("status lamp not steady for effective messages");

  turn_flash_a: assert property (!state_reg.in_turn && state_reg.near_turn |=>
    turn_point_lamp == $past(flash_on))
    else $error("turn lamp not flashing near turn point");

  turn_steady_a: assert property (state_reg.in_turn |=> turn_point_lamp)
    else $error("turn lamp not steady in turn");

  arrival_window_a: assert property (alarm_entry_seq |=> arrival_flash_seq)
    else $error("arrival alarm window not started");

  arrival_plain_a: assert property (!state_reg.in_turn && !state_reg.alarm_set && state_reg.near_arrival |=>
    turn_point_lamp == $past(flash_on))
    else $error("turn lamp not flashing near arrival");

  source_toggle_a: assert property (src_fall |=> src_gps_reg != $past(src_gps_reg))
    else $error("source press did not toggle source");

  hold_toggle_a: assert property (hold_fall |=> course_hold_mode_reg != $past(course_hold_mode_reg))
    else $error("hold press did not toggle mode");

  source_lamps_a: assert property ((radio_nav_lamp || satellite_nav_lamp) |->
    $past(state_reg.single_indicator) && (satellite_nav_lamp == $past(src_gps_reg)))
    else $error("source lamp lit without single indicator");

  hold_lamps_a: assert property (hold_shown |=> course_hold_lamp && !leg_sequencing_lamp)
    else $error("hold lamps wrong while hold shown");

  leg_lamps_a: assert property (!hold_shown |=> leg_sequencing_lamp && !course_hold_lamp)
    else $error("leg lamps wrong while no hold shown");

  approach_lamps_a: assert property (##1 near_airport_lamp == $past(state_reg.approach_nav &&
    state_reg.within_30nm && state_reg.scale_le_1nm) &&
    final_segment_lamp == $past(state_reg.approach_nav && state_reg.appr_active))
    else $error("approach lamps disagree with state");

  trust_lamp_a: assert property ((state_reg.pos_error || state_reg.integ_unavail) |=> position_trust_lamp)
    else $error("trust lamp dark with integrity fault");

  gain_a: assert property (precision_gain_output |-> $past(src_gps_reg ? state_reg.gps_appr_active :
    state_reg.ils_tuned))
    else $error("precision gain active without approach");

  strap_a: assert property ($rose(strap_taken_reg) |-> sim_mode_reg == !$past(sim_select_n) ##1
    $stable(sim_mode_reg)[*2])
    else $error("simulation strap sampled wrongly");
endmodule // nas_annunciator

// *** design/nas_pkg.sv ***
// constants, register map and carrier types for the annunciator and switch logic
package nas_pkg;
  // -------------------------------------------------------------------------
  // clock and timing
  // -------------------------------------------------------------------------
  localparam longint unsigned CLK_HZ = 64'h0ee6_b280;
  localparam longint unsigned ARRIVAL_FLASH_S = 64'h0a;
  localparam longint unsigned ARRIVAL_FLASH_CYC = ARRIVAL_FLASH_S * CLK_HZ;
  localparam longint unsigned DEBOUNCE_MS = 64'h0a;
  localparam longint unsigned DEBOUNCE_CYC = (DEBOUNCE_MS * CLK_HZ) / 64'h3e8;
  localparam longint unsigned FLASH_HALF_MS = 64'h1f4;
  localparam longint unsigned FLASH_HALF_CYC = (FLASH_HALF_MS * CLK_HZ) / 64'h3e8;

  // -------------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------------
  localparam logic [7:0] OFF_NAV_STATE = 8'h00;
  localparam logic [7:0] OFF_FLASH_HALF = 8'h04;
  localparam logic [7:0] OFF_KEY = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam int KEY_SRC_BIT = 0;
  localparam int KEY_HOLD_BIT = 1;
  localparam int STAT_GPS_BIT = 0;
  localparam int STAT_HOLD_BIT = 1;
  localparam int STAT_SIM_BIT = 2;
  localparam int STAT_LAMP_LSB = 8;
  localparam logic [16:0] NAV_STATE_RST = 17'h0_0000;
  localparam logic [31:0] FLASH_HALF_RST = FLASH_HALF_CYC[31:0];
  localparam logic SRC_GPS_RST = 1'b1;

  // navigation state written by software, bit 0 is new_msg
  typedef struct packed {
    logic leg_suspend;
    logic ils_tuned;
    logic gps_appr_active;
    logic integ_unavail;
    logic pos_error;
    logic appr_active;
    logic scale_le_1nm;
    logic within_30nm;
    logic approach_nav;
    logic single_indicator;
    logic near_arrival;
    logic in_alarm_radius;
    logic alarm_set;
    logic in_turn;
    logic near_turn;
    logic msgs_active;
    logic new_msg;
  } nas_nav_state_s;

  typedef struct packed {
    logic precision_gain_output;
    logic position_trust_lamp;
    logic final_segment_lamp;
    logic near_airport_lamp;
    logic course_hold_lamp;
    logic leg_sequencing_lamp;
    logic satellite_nav_lamp;
    logic radio_nav_lamp;
    logic turn_point_lamp;
    logic status_note_lamp;
  } nas_lamps_s;
endpackage

// *** design/nas_debounce.sv ***
// synchroniser, debouncer and falling-edge detector for one grounded discrete
`timescale 1ns/1ps
module nas_debounce #(
  parameter logic [31:0] STABLE_CYC = nas_pkg::DEBOUNCE_CYC[31:0]
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic pin_n,
  output logic fall_pulse
);
  logic sync1_reg;
  logic sync2_reg;
  logic level_reg;
  logic [31:0] stable_cnt_reg;

  // inactive level is high: an open switch must not toggle at reset
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= pin_n;
      sync2_reg <= sync1_reg;
    end
  end

  // level accepted only after it stays put for the whole window
  always_ff @(posedge clk) begin
    if (srst) begin
      stable_cnt_reg <= 32'h0;
      level_reg <= 1'b1;
    end else if (sync2_reg == level_reg) begin
      stable_cnt_reg <= 32'h0;
    end else if (stable_cnt_reg >= STABLE_CYC - 32'h1) begin
      stable_cnt_reg <= 32'h0;
      level_reg <= sync2_reg;
    end else begin
      stable_cnt_reg <= stable_cnt_reg + 32'h1;
    end
  end

  // one pulse per accepted high-to-low change, bounce cannot add more
  always_ff @(posedge clk) begin
    if (srst) begin
      fall_pulse <= 1'b0;
    end else begin
      fall_pulse <= level_reg && !sync2_reg && (stable_cnt_reg >= STABLE_CYC - 32'h1);
    end
  end

  single_press_a: assert property (@(posedge clk) disable iff (srst) fall_pulse |-> !level_reg ##1 !fall_pulse)
    else $error("press gave more than one toggle pulse");
endmodule // nas_debounce

// *** design/nas_flash.sv ***
// common on/off flash timing for every flashing lamp
`timescale 1ns/1ps
module nas_flash (
  input wire logic clk,
  input wire logic srst,
  input wire logic [31:0] half_period,
  output logic flash_on
);
  logic [31:0] cnt_reg;
  logic [31:0] limit;

  // a zero period would stall the phase, so it acts as one cycle
  assign limit = (half_period == 32'h0) ? 32'h0 : half_period - 32'h1;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= 32'h0;
      flash_on <= 1'b1;
    end else if (cnt_reg >= limit) begin
      cnt_reg <= 32'h0;
      flash_on <= !flash_on;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
    end
  end

  flash_phase_a: assert property (@(posedge clk) disable iff (srst)
    (cnt_reg < limit) |=> $stable(flash_on))
    else $error("flash phase changed before its half period");
endmodule // nas_flash

// *** verif/nas_panel_model.sv ***
// panel switches and simulation strap that drive the grounded discrete inputs
`timescale 1ns/1ps
module nas_panel_model (
  output logic src_n,
  output logic hold_n,
  output logic strap_n,
  input wire logic clk
);
  // -------------------------------------------------------------------------
  // idle levels
  // -------------------------------------------------------------------------
  // released discretes are pulled up, so they read high between presses
  initial begin
    src_n = 1'b1;
    hold_n = 1'b1;
    strap_n = 1'b0;
  end

  // -------------------------------------------------------------------------
  // actions
  // -------------------------------------------------------------------------
  // only a momentary ground, then a long release so the debouncer rearms
  task automatic press(input bit hold, input int n);
    @(posedge clk);
    if (hold) begin
      hold_n <= 1'b0;
    end else begin
      src_n <= 1'b0;
    end
    repeat (n) @(posedge clk);
    hold_n <= 1'b1;
    src_n <= 1'b1;
    repeat (12) @(posedge clk);
  endtask

  task automatic strap(input logic v);
    @(posedge clk);
    strap_n <= v;
  endtask
endmodule // nas_panel_model

// *** verif/nas_annunciator_tb.sv ***
// self-checking testbench for the annunciator and switch logic
`timescale 1ns/1ps
module nas_annunciator_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic src_n;
  logic hold_n;
  logic strap_n;
  wire nas_pkg::nas_lamps_s lamps;
  nas_pkg::nas_nav_state_s ns;
  int fails = 0;
  int n_checks = 0;
  int o;

  always #2 clk = ~clk;

  nas_panel_model u_nas_panel_model (.src_n(src_n), .hold_n(hold_n), .strap_n(strap_n), .clk(clk));

  // short counts keep the arrival window and debounce within a quick run
  nas_annunciator #(.ARRIVAL_CYC(32'h14), .DEBOUNCE_CYC(32'h4)) u_nas_annunciator (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .nav_source_toggle_input_n(src_n), .course_hold_toggle_input_n(hold_n), .sim_select_n(strap_n),
    .status_note_lamp(lamps.status_note_lamp), .turn_point_lamp(lamps.turn_point_lamp),
    .radio_nav_lamp(lamps.radio_nav_lamp), .satellite_nav_lamp(lamps.satellite_nav_lamp),
    .leg_sequencing_lamp(lamps.leg_sequencing_lamp), .course_hold_lamp(lamps.course_hold_lamp),
    .near_airport_lamp(lamps.near_airport_lamp), .final_segment_lamp(lamps.final_segment_lamp),
    .position_trust_lamp(lamps.position_trust_lamp), .precision_gain_output(lamps.precision_gain_output)
  );

  // -------------------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------------------
  task automatic results();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic setns();
    wr(nas_pkg::OFF_NAV_STATE, 32'(ns));
    settle();
  endtask

  task automatic lv(input int i, input logic v);
    chk(32'(lamps[i]), 32'(v));
  endtask

  task automatic watch(input int i, input int n);
    o = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (lamps[i] === 1'b1) o++;
    end
  endtask

  task automatic flash(input int i, input int n);
    watch(i, n);
    chk(32'(o > 0 && o < n), 32'h1);
    chk(o, n / 2);
  endtask

  task automatic rst();
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    #1;
    chk(32'(lamps), 32'h0);
    @(posedge clk);
    srst <= 1'b0;
    settle();
  endtask

  // -------------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------------
  task automatic t_reset();
    rst();
    rd(nas_pkg::OFF_STATUS);
    chk(d, 32'h0000_1005);
    rd(nas_pkg::OFF_FLASH_HALF);
    chk(d, nas_pkg::FLASH_HALF_RST);
    u_nas_panel_model.strap(1'b1);
    rd(nas_pkg::OFF_STATUS);
    chk(d, 32'h0000_1005);
    rst();
    rd(nas_pkg::OFF_STATUS);
    chk(d, 32'h0000_1001);
  endtask

  task automatic t_regs();
    ns = '0;
    ns.near_turn = 1'b1;
    ns.leg_suspend = 1'b1;
    setns();
    rd(nas_pkg::OFF_NAV_STATE);
    chk(d, 32'(ns));
    @(posedge clk);
    #1;
    chk(rdata, 32'h0);
    rd(8'h10);
    chk(d, 32'h0);
    rd(nas_pkg::OFF_KEY);
    chk(d, 32'h0);
    wr(8'h20, 32'hffff_ffff);
    rd(nas_pkg::OFF_NAV_STATE);
    chk(d, 32'(ns));
  endtask

  task automatic t_msg();
    ns = '0;
    ns.new_msg = 1'b1;
    ns.msgs_active = 1'b1;
    ns.near_turn = 1'b1;
    setns();
    flash(0, 24);
    repeat (24) begin
      @(posedge clk);
      #1;
      chk(32'(lamps.status_note_lamp), 32'(lamps.turn_point_lamp));
    end
    ns.new_msg = 1'b0;
    ns.near_turn = 1'b0;
    setns();
    watch(0, 24);
    chk(o, 24);
  endtask

  task automatic t_turn();
    ns = '0;
    ns.near_turn = 1'b1;
    setns();
    flash(1, 24);
    ns.in_turn = 1'b1;
    setns();
    watch(1, 24);
    chk(o, 24);
    ns = '0;
    ns.alarm_set = 1'b1;
    setns();
    lv(1, 1'b0);
    ns.in_alarm_radius = 1'b1;
    setns();
    flash(1, 16);
    repeat (8) @(posedge clk);
    watch(1, 12);
    chk(o, 0);
    ns = '0;
    ns.near_arrival = 1'b1;
    setns();
    flash(1, 24);
  endtask

  task automatic t_src();
    ns = '0;
    ns.single_indicator = 1'b1;
    setns();
    lv(3, 1'b1);
    lv(2, 1'b0);
    u_nas_panel_model.press(1'b0, 8);
    lv(2, 1'b1);
    lv(3, 1'b0);
    rd(nas_pkg::OFF_STATUS);
    chk(32'(d[0]), 32'h0);
    u_nas_panel_model.press(1'b0, 2);
    lv(2, 1'b1);
    wr(nas_pkg::OFF_KEY, 32'h1);
    settle();
    lv(3, 1'b1);
    ns.single_indicator = 1'b0;
    setns();
    lv(3, 1'b0);
    lv(2, 1'b0);
  endtask

  task automatic t_hold();
    ns = '0;
    setns();
    lv(4, 1'b1);
    lv(5, 1'b0);
    u_nas_panel_model.press(1'b1, 30);
    lv(5, 1'b1);
    lv(4, 1'b0);
    rd(nas_pkg::OFF_STATUS);
    chk(32'(d[1]), 32'h1);
    u_nas_panel_model.press(1'b1, 8);
    lv(4, 1'b1);
    ns.leg_suspend = 1'b1;
    setns();
    lv(5, 1'b1);
    lv(4, 1'b0);
  endtask

  task automatic t_appr();
    ns = '0;
    ns.approach_nav = 1'b1;
    ns.within_30nm = 1'b1;
    ns.scale_le_1nm = 1'b1;
    setns();
    lv(6, 1'b1);
    ns.within_30nm = 1'b0;
    setns();
    lv(6, 1'b0);
    lv(7, 1'b0);
    ns.appr_active = 1'b1;
    setns();
    lv(7, 1'b1);
    ns = '0;
    ns.pos_error = 1'b1;
    setns();
    lv(8, 1'b1);
    ns = '0;
    ns.integ_unavail = 1'b1;
    setns();
    lv(8, 1'b1);
    ns = '0;
    setns();
    lv(8, 1'b0);
  endtask

  task automatic t_gain();
    ns = '0;
    ns.gps_appr_active = 1'b1;
    setns();
    lv(9, 1'b1);
    ns = '0;
    ns.ils_tuned = 1'b1;
    setns();
    lv(9, 1'b0);
    wr(nas_pkg::OFF_KEY, 32'h1);
    settle();
    lv(9, 1'b1);
    ns = '0;
    ns.gps_appr_active = 1'b1;
    setns();
    lv(9, 1'b0);
  endtask

  // -------------------------------------------------------------------------
  // sequence and watchdog
  // -------------------------------------------------------------------------
  initial begin
    t_reset();
    wr(nas_pkg::OFF_FLASH_HALF, 32'h4);
    t_regs();
    t_msg();
    t_turn();
    t_src();
    t_hold();
    t_appr();
    t_gain();
    results();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end
endmodule // nas_annunciator_tb
